// [design/adcsf_top.sv]
// Status flag register bank for a dual sigma-delta converter subsystem.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module adcsf_top
  import adcsf_pkg::*;
#(
  parameter int DATA_W   = 24,
  parameter int ACC_W    = 32,
  parameter int CNT_W    = 16,
  parameter int OVR_CYC  = OVR_PERIOD_CYC
) (
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  input  wire logic [7:0]        addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [31:0]       rdata_o,
  input  wire logic              cal_end_i,
  input  wire logic              pri_en_i,
  input  wire logic              aux_en_i,
  input  wire logic              core_pd_i,
  input  wire logic              pri_valid_i,
  input  wire logic [DATA_W-1:0] pri_data_i,
  input  wire logic              pri_over_i,
  input  wire logic              pri_under_i,
  input  wire logic              aux_valid_i,
  input  wire logic [DATA_W-1:0] aux_data_i,
  input  wire logic              aux_over_i,
  input  wire logic              aux_under_i,
  input  wire logic [ACC_W-1:0]  acc_value_i,
  input  wire logic              gross_ovr_i,
  output logic                   irq_o
);
  // ===========================================================================
  // Register port decode
  localparam logic [DATA_W-1:0] POS_FS = {1'b0, {(DATA_W-1){1'b1}}};
  localparam logic [DATA_W-1:0] NEG_FS = {1'b1, {(DATA_W-1){1'b0}}};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  function automatic logic [DATA_W-1:0] mag(input logic [DATA_W-1:0] v);
    mag = v[DATA_W-1] ? DATA_W'(~v + 1'b1) : v;
  endfunction : mag

  logic [15:0]       status_r;
  logic [7:0]        mask_r;
  logic [7:0]        mode_r;
  logic [7:0]        cfg_r;
  logic [7:0]        pctrl_r;
  logic [DATA_W-1:0] pri_dat_r;
  logic [DATA_W-1:0] aux_dat_r;
  logic [DATA_W-1:0] pri_thr_r;
  logic [ACC_W-1:0]  acc_thr_r;
  logic [CNT_W-1:0]  cnt_tgt_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [31:0]       ovr_cnt_r;
  adcsf_rd_t         rd_st_r;
  logic [31:0]       rdata_r;
  logic              irq_r;
  logic              gross_s1_r;
  logic              gross_s2_r;

  wire wr_mode  = wr_i & hit(addr_i, ADDR_MODE);
  wire wr_cfg   = wr_i & hit(addr_i, ADDR_CONFIG);
  wire wr_pctrl = wr_i & hit(addr_i, ADDR_PRI_CTRL);
  wire rd_pri   = rd_i & hit(addr_i, ADDR_PRI_RESULT);
  wire rd_aux   = rd_i & hit(addr_i, ADDR_AUX_RESULT);

  // ===========================================================================
  // Result capture
  wire pri_rdy = status_r[BIT_PRI_RDY];
  wire aux_rdy = status_r[BIT_AUX_RDY];
  wire pri_store = pri_valid_i & pri_en_i & (~pri_rdy | core_pd_i);
  wire aux_store = aux_valid_i & aux_en_i & (~aux_rdy | core_pd_i);
  wire pri_oor   = pri_over_i | pri_under_i;
  wire aux_oor   = aux_over_i | aux_under_i;
  wire [DATA_W-1:0] pri_sat = pri_over_i ? POS_FS :
                              pri_under_i ? NEG_FS : pri_data_i;
  wire [DATA_W-1:0] aux_sat = aux_over_i ? POS_FS :
                              aux_under_i ? NEG_FS : aux_data_i;

  // Threshold comparison uses the incoming, saturated value, before it is stored.
  wire pri_above = mag(pri_sat) > pri_thr_r;
  wire cmp_en    = cfg_r[CFG_CMP_EN];
  wire cnt_en    = cfg_r[CFG_CNT_EN];
  wire [CNT_W-1:0] cnt_nxt = (pri_above) ? CNT_W'(cnt_r + 1'b1) : cnt_r;
  wire gain_chg  = wr_pctrl &
    (wdata_i[PRI_GAIN_LSB +: PRI_GAIN_W] !=
     pctrl_r[PRI_GAIN_LSB +: PRI_GAIN_W]);
  wire ovr_tick  = (ovr_cnt_r == 32'(OVR_CYC - 1));

  // ===========================================================================
  // Status flags; set beats clear where both occur in one cycle, except that CFG_OVR_EN and CFG_CMP_EN low hold the gross overrange and threshold flags clear.
  logic [15:0] status_nxt;
  always_comb begin
    status_nxt = status_r;
    if (wr_mode) begin
      status_nxt[BIT_CAL_DONE] = 1'b0;
    end
    if (cal_end_i) begin
      status_nxt[BIT_CAL_DONE] = 1'b1;
    end
    if (aux_store) begin
      status_nxt[BIT_AUX_ERR] = aux_oor;
    end
    if (pri_store) begin
      status_nxt[BIT_PRI_ERR] = pri_oor;
    end
    status_nxt[BIT_ACC_THR] = acc_value_i > acc_thr_r;
    if (!cmp_en) begin
      status_nxt[BIT_PRI_THR] = 1'b0;
    end else if (pri_store) begin
      if (cnt_en) begin
        status_nxt[BIT_PRI_THR] = (cnt_nxt == cnt_tgt_r);
      end else begin
        status_nxt[BIT_PRI_THR] = pri_above;
      end
    end
    if (!cfg_r[CFG_OVR_EN]) begin
      status_nxt[BIT_GROSS_OVR] = 1'b0;
    end else if (ovr_tick && gross_s2_r) begin
      status_nxt[BIT_GROSS_OVR] = 1'b1;
    end else if (gain_chg) begin
      status_nxt[BIT_GROSS_OVR] = 1'b0;
    end
    if (rd_pri) begin
      status_nxt[BIT_PRI_RDY] = 1'b0;
      if (rd_st_r == ADCSF_RD_AUX) begin
        status_nxt[BIT_AUX_RDY] = 1'b0;
      end
    end
    if (aux_store || (cal_end_i && aux_en_i)) begin
      status_nxt[BIT_AUX_RDY] = 1'b1;
    end
    if (pri_store || (cal_end_i && pri_en_i)) begin
      status_nxt[BIT_PRI_RDY] = 1'b1;
    end
    status_nxt = status_nxt & ~STATUS_RSVD;
  end

  // ===========================================================================
  // Read mux; a status read only selects data.
  logic [31:0] rd_mux;
  always_comb begin
    case (addr_i)
      ADDR_STATUS:     rd_mux = {16'h0000, status_r};
      ADDR_IRQ_MASK:   rd_mux = {24'h000000, mask_r};
      ADDR_MODE:       rd_mux = {24'h000000, mode_r};
      ADDR_CONFIG:     rd_mux = {24'h000000, cfg_r};
      ADDR_PRI_CTRL:   rd_mux = {24'h000000, pctrl_r};
      ADDR_PRI_RESULT: rd_mux = 32'(signed'(pri_dat_r));
      ADDR_AUX_RESULT: rd_mux = 32'(signed'(aux_dat_r));
      ADDR_PRI_THR:    rd_mux = 32'(pri_thr_r);
      ADDR_ACC_THR:    rd_mux = 32'(acc_thr_r);
      ADDR_CNT_TARGET: rd_mux = 32'(cnt_tgt_r);
      ADDR_CNT_VALUE:  rd_mux = 32'(cnt_r);
      ADDR_ACC_VALUE:  rd_mux = 32'(acc_value_i);
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // ===========================================================================
  // Sequential state
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      status_r   <= STATUS_RST;
      mask_r     <= MASK_RST;
      mode_r     <= MODE_RST;
      cfg_r      <= 8'h00;
      pctrl_r    <= 8'h00;
      pri_dat_r  <= '0;
      aux_dat_r  <= '0;
      pri_thr_r  <= '0;
      acc_thr_r  <= '0;
      cnt_tgt_r  <= '0;
      cnt_r      <= '0;
      ovr_cnt_r  <= 32'h00000000;
      rd_st_r    <= ADCSF_RD_IDLE;
      rdata_r    <= 32'h00000000;
      irq_r      <= 1'b0;
      gross_s1_r <= 1'b0;
      gross_s2_r <= 1'b0;
    end else begin
      status_r   <= status_nxt;
      gross_s1_r <= gross_ovr_i;
      gross_s2_r <= gross_s1_r;
      ovr_cnt_r  <= ovr_tick ? 32'h00000000 : ovr_cnt_r + 32'h00000001;
      rdata_r    <= rd_i ? rd_mux : 32'h00000000;
      irq_r      <= |(status_nxt[7:0] & mask_r);
      if (pri_store) begin
        pri_dat_r <= pri_sat;
        if (cmp_en && cnt_en) begin
          cnt_r <= (cnt_nxt == cnt_tgt_r) ? '0 : cnt_nxt;
        end
      end
      if (aux_store) begin
        aux_dat_r <= aux_sat;
      end
      if (rd_aux) begin
        rd_st_r <= ADCSF_RD_AUX;
      end else if (rd_pri) begin
        rd_st_r <= ADCSF_RD_IDLE;
      end
      if (wr_i) begin
        case (addr_i)
          ADDR_IRQ_MASK:   mask_r    <= wdata_i[7:0];
          ADDR_MODE:       mode_r    <= wdata_i[7:0];
          ADDR_CONFIG:     cfg_r     <= wdata_i[7:0];
          ADDR_PRI_CTRL:   pctrl_r   <= wdata_i[7:0];
          ADDR_PRI_THR:    pri_thr_r <= wdata_i[DATA_W-1:0];
          ADDR_ACC_THR:    acc_thr_r <= wdata_i[ACC_W-1:0];
          ADDR_CNT_TARGET: cnt_tgt_r <= wdata_i[CNT_W-1:0];
          default:         ;
        endcase
      end
    end
  end

  assign rdata_o = rdata_r;
  assign irq_o   = irq_r;

  // ===========================================================================
  // Assertions
  property p_cal_set;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      cal_end_i |=> status_r[BIT_CAL_DONE];
  endproperty
  a_cal_set: assert property (p_cal_set) else $error("cal flag not set");

  property p_cal_clr;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      wr_mode && !cal_end_i |=> !status_r[BIT_CAL_DONE];
  endproperty
  a_cal_clr: assert property (p_cal_clr) else $error("cal flag kept");

  property p_pri_err;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      pri_store |=> status_r[BIT_PRI_ERR] == $past(pri_oor);
  endproperty
  a_pri_err: assert property (p_pri_err) else $error("pri err wrong");

  property p_aux_err;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      aux_store |=> status_r[BIT_AUX_ERR] == $past(aux_oor);
  endproperty
  a_aux_err: assert property (p_aux_err) else $error("aux err wrong");

  property p_sat;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      pri_store && pri_over_i |=> pri_dat_r == POS_FS;
  endproperty
  a_sat: assert property (p_sat) else $error("no saturation");

  property p_acc;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      ##1 status_r[BIT_ACC_THR] == ($past(acc_value_i) > $past(acc_thr_r));
  endproperty
  a_acc: assert property (p_acc) else $error("acc flag wrong");

  property p_ovr_hold;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      status_r[BIT_GROSS_OVR] && cfg_r[CFG_OVR_EN] && !gain_chg
        |=> status_r[BIT_GROSS_OVR];
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("ovr dropped");

  property p_ovr_tick;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      $rose(status_r[BIT_GROSS_OVR]) |-> $past(ovr_tick);
  endproperty
  a_ovr_tick: assert property (p_ovr_tick) else $error("ovr off tick");

  property p_rdy_clr;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      rd_pri && !pri_store && !(cal_end_i && pri_en_i)
        |=> !status_r[BIT_PRI_RDY];
  endproperty
  a_rdy_clr: assert property (p_rdy_clr) else $error("pri rdy kept");

  property p_hold;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      pri_rdy && !core_pd_i |=> pri_dat_r == $past(pri_dat_r);
  endproperty
  a_hold: assert property (p_hold) else $error("result overwritten");

  property p_irq;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      ##1 irq_o == |(status_r[7:0] & $past(mask_r));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_rst_zero;
    @(posedge ref_clk_i)
      !nrst_i |=> status_r == STATUS_RST;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("status not zero");

  property p_rsvd;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (status_r & STATUS_RSVD) == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

  property p_pri_rdy_set;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      pri_store || (cal_end_i && pri_en_i) |=> status_r[BIT_PRI_RDY];
  endproperty
  a_pri_rdy_set: assert property (p_pri_rdy_set) else $error("pri rdy");

  property p_aux_rdy_set;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      aux_store || (cal_end_i && aux_en_i) |=> status_r[BIT_AUX_RDY];
  endproperty
  a_aux_rdy_set: assert property (p_aux_rdy_set) else $error("aux rdy");

  // Only a primary read that follows an auxiliary read may drop bit 1.
  property p_aux_rdy_keep;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      aux_rdy && !(rd_pri && rd_st_r == ADCSF_RD_AUX)
        |=> status_r[BIT_AUX_RDY];
  endproperty
  a_aux_rdy_keep: assert property (p_aux_rdy_keep) else $error("aux rdy");

  property p_thr_off;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      !cmp_en |=> !status_r[BIT_PRI_THR];
  endproperty
  a_thr_off: assert property (p_thr_off) else $error("thr flag on");

  property p_thr_mag;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      cmp_en && !cnt_en && pri_store
        |=> status_r[BIT_PRI_THR] == $past(pri_above);
  endproperty
  a_thr_mag: assert property (p_thr_mag) else $error("thr flag wrong");

  property p_cnt_hit;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      cmp_en && cnt_en && pri_store
        |=> status_r[BIT_PRI_THR] == ($past(cnt_nxt) == $past(cnt_tgt_r));
  endproperty
  a_cnt_hit: assert property (p_cnt_hit) else $error("count flag wrong");

  property p_ovr_off;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      !cfg_r[CFG_OVR_EN] |=> !status_r[BIT_GROSS_OVR];
  endproperty
  a_ovr_off: assert property (p_ovr_off) else $error("ovr while off");
endmodule : adcsf_top
`default_nettype wire

// [design/adcsf_pkg.sv]
// Package of constants for the converter status flag block.
package adcsf_pkg;
  // ===========================================================================
  // Register map (word byte addresses on the local register port)
  localparam logic [7:0] ADDR_STATUS     = 8'h00;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h04;
  localparam logic [7:0] ADDR_MODE       = 8'h08;
  localparam logic [7:0] ADDR_CONFIG     = 8'h0c;
  localparam logic [7:0] ADDR_PRI_CTRL   = 8'h10;
  localparam logic [7:0] ADDR_PRI_RESULT = 8'h14;
  localparam logic [7:0] ADDR_AUX_RESULT = 8'h18;
  localparam logic [7:0] ADDR_PRI_THR    = 8'h1c;
  localparam logic [7:0] ADDR_ACC_THR    = 8'h20;
  localparam logic [7:0] ADDR_CNT_TARGET = 8'h24;
  localparam logic [7:0] ADDR_CNT_VALUE  = 8'h28;
  localparam logic [7:0] ADDR_ACC_VALUE  = 8'h2c;
  // ===========================================================================
  // Status bit positions
  localparam int BIT_CAL_DONE  = 15;
  localparam int BIT_AUX_ERR   = 13;
  localparam int BIT_PRI_ERR   = 12;
  localparam int BIT_ACC_THR   = 6;
  localparam int BIT_PRI_THR   = 4;
  localparam int BIT_GROSS_OVR = 3;
  localparam int BIT_AUX_RDY   = 1;
  localparam int BIT_PRI_RDY   = 0;
  // ===========================================================================
  // Configuration bit positions and reset values
  localparam int CFG_CMP_EN    = 3;
  localparam int CFG_CNT_EN    = 4;
  localparam int CFG_OVR_EN    = 2;
  localparam int PRI_GAIN_LSB  = 0;
  localparam int PRI_GAIN_W    = 4;
  localparam logic [15:0] STATUS_RST   = 16'h0000;
  localparam logic [15:0] STATUS_RSVD  = 16'h4fa4;
  localparam logic [7:0]  MASK_RST     = 8'h00;
  localparam logic [7:0]  MODE_RST     = 8'h03;
  // ===========================================================================
  // Timing
  localparam int CLK_HZ        = 100_000_000;
  localparam int OVR_PERIOD_US = 125;
  localparam int OVR_PERIOD_CYC = OVR_PERIOD_US * (CLK_HZ / 1_000_000);
  // ===========================================================================
  typedef enum logic [1:0] {
    ADCSF_RD_IDLE = 2'b01,
    ADCSF_RD_AUX  = 2'b10
  } adcsf_rd_t;
endpackage : adcsf_pkg

// [dv/adcsf_top_tb.sv]
// Self-checking bench for the converter status flag block.
`timescale 1ns/1ns
`default_nettype none
module adcsf_top_tb;
  import adcsf_pkg::*;
  // ===========================================================================
  // Signals and instance
  localparam int OVR = 16;
  logic        ref_clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic        cal_end_i = 1'b0, pri_en_i = 1'b0, aux_en_i = 1'b0;
  logic        core_pd_i = 1'b0, gross_ovr_i = 1'b0;
  logic        pri_valid_i = 1'b0, pri_over_i = 1'b0, pri_under_i = 1'b0;
  logic        aux_valid_i = 1'b0, aux_over_i = 1'b0, aux_under_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, acc_value_i = 32'h0, rdata_o, seed = 32'ha3f;
  logic [23:0] pri_data_i = 24'h0, aux_data_i = 24'h0;
  logic        irq_o;
  int          n_mismatch = 0, checks_done = 0;
  logic [31:0] r, t, rb;
  logic [23:0] d;

  adcsf_top #(.OVR_CYC(OVR)) i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .cal_end_i(cal_end_i), .pri_en_i(pri_en_i),
    .aux_en_i(aux_en_i), .core_pd_i(core_pd_i), .pri_valid_i(pri_valid_i),
    .pri_data_i(pri_data_i), .pri_over_i(pri_over_i),
    .pri_under_i(pri_under_i), .aux_valid_i(aux_valid_i),
    .aux_data_i(aux_data_i), .aux_over_i(aux_over_i),
    .aux_under_i(aux_under_i), .acc_value_i(acc_value_i),
    .gross_ovr_i(gross_ovr_i), .irq_o(irq_o));

  always #5 ref_clk_i = ~ref_clk_i;
  // ===========================================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // Magnitude compare; the 24-bit negation keeps the most negative value big.
  function automatic logic hit(input logic [23:0] v, input logic [31:0] th);
    logic [23:0] m;
    m = v[23] ? -v : v;
    return {8'h0, m} > th;
  endfunction : hit
  function automatic logic [31:0] ext(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction : ext
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
    wdata_i <= ~v;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(nm, e, v);
  endtask : rchk
  // One result pulse on the primary (aux=0) or auxiliary channel.
  task automatic res(input logic aux, input logic [23:0] v, input logic ov,
                     input logic un);
    @(posedge ref_clk_i);
    {aux_valid_i, aux_over_i, aux_under_i} <= aux ? {1'b1, ov, un} : 3'b0;
    {pri_valid_i, pri_over_i, pri_under_i} <= aux ? 3'b0 : {1'b1, ov, un};
    pri_data_i <= v;
    aux_data_i <= v;
    @(posedge ref_clk_i);
    {aux_valid_i, aux_over_i, aux_under_i} <= 3'b0;
    {pri_valid_i, pri_over_i, pri_under_i} <= 3'b0;
    pri_data_i <= ~v;
    aux_data_i <= ~v;
    @(posedge ref_clk_i);
  endtask : res
  task automatic complete_run();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // ===========================================================================
  // Watchdog; the sequence needs well under a third of this span.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    complete_run();
  end
  // ===========================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rchk("status", ADDR_STATUS, 32'h0);
    rchk("mask", ADDR_IRQ_MASK, {24'h0, MASK_RST});
    rchk("mode", ADDR_MODE, {24'h0, MODE_RST});
    rchk("unmapped", 8'h30, 32'h0);
    wr(ADDR_STATUS, 32'hffff);
    rchk("status", ADDR_STATUS, 32'h0);
    pri_en_i <= 1'b1;
    aux_en_i <= 1'b1;
    @(posedge ref_clk_i);
    cal_end_i <= 1'b1;
    @(posedge ref_clk_i);
    cal_end_i <= 1'b0;
    rchk("status", ADDR_STATUS, 32'h8003);
    rchk("status", ADDR_STATUS, 32'h8003);
    wr(ADDR_MODE, 32'h3);
    rchk("status", ADDR_STATUS, 32'h0003);
    rd(ADDR_AUX_RESULT, rb);
    rchk("status", ADDR_STATUS, 32'h0003);
    rd(ADDR_PRI_RESULT, rb);
    rchk("status", ADDR_STATUS, 32'h0);
    // Comparator on: magnitude against threshold, equality among corners.
    wr(ADDR_CONFIG, 32'h8);
    for (int i = 0; i < 10; i++) begin
      r = xs();
      t = {9'h0, r[22:0]};
      r = xs();
      d = (i == 0) ? t[23:0] : (i == 1) ? t[23:0] + 24'h1 :
          (i == 2) ? -t[23:0] : r[23:0];
      wr(ADDR_PRI_THR, t);
      res(1'b0, d, 1'b0, 1'b0);
      rchk("status", ADDR_STATUS, {27'h0, hit(d, t), 4'h1});
      rchk("pri_result", ADDR_PRI_RESULT, ext(d));
      rchk("status", ADDR_STATUS, {27'h0, hit(d, t), 4'h0});
    end
    wr(ADDR_CONFIG, 32'h0);
    wr(ADDR_PRI_THR, 32'h0);
    res(1'b0, 24'h123456, 1'b1, 1'b0);
    rchk("status", ADDR_STATUS, 32'h1001);
    rchk("pri_result", ADDR_PRI_RESULT, 32'h007fffff);
    res(1'b0, 24'h000001, 1'b0, 1'b1);
    rchk("pri_result", ADDR_PRI_RESULT, 32'hff800000);
    res(1'b0, 24'h000042, 1'b0, 1'b0);
    res(1'b0, 24'h000099, 1'b0, 1'b0);
    rchk("status", ADDR_STATUS, 32'h0001);
    rchk("pri_result", ADDR_PRI_RESULT, 32'h42);
    core_pd_i <= 1'b1;
    res(1'b0, 24'h000011, 1'b0, 1'b0);
    res(1'b0, 24'hfffff0, 1'b0, 1'b0);
    rchk("pri_result", ADDR_PRI_RESULT, 32'hfffffff0);
    core_pd_i <= 1'b0;
    res(1'b1, 24'h000005, 1'b1, 1'b0);
    rchk("status", ADDR_STATUS, 32'h2002);
    rchk("aux_result", ADDR_AUX_RESULT, 32'h007fffff);
    rd(ADDR_PRI_RESULT, rb);
    res(1'b1, 24'h0abcde, 1'b0, 1'b0);
    rchk("status", ADDR_STATUS, 32'h0002);
    rchk("aux_result", ADDR_AUX_RESULT, 32'h000abcde);
    rd(ADDR_PRI_RESULT, rb);
    rchk("status", ADDR_STATUS, 32'h0);
    // Primary off: a lone primary read must not drop the aux ready bit.
    pri_en_i <= 1'b0;
    res(1'b1, 24'h000321, 1'b0, 1'b0);
    rd(ADDR_PRI_RESULT, rb);
    rchk("status", ADDR_STATUS, 32'h0002);
    rd(ADDR_AUX_RESULT, rb);
    rd(ADDR_PRI_RESULT, rb);
    rchk("status", ADDR_STATUS, 32'h0);
    pri_en_i <= 1'b1;
    // Accumulator level compare, boundary first.
    wr(ADDR_ACC_THR, 32'h1000);
    for (int i = 0; i < 5; i++) begin
      r = (i == 0) ? 32'h1000 : (i == 1) ? 32'h1001 : xs() >> (i * 8);
      acc_value_i <= r;
      rchk("status", ADDR_STATUS, {25'h0, r > 32'h1000, 6'h0});
      rchk("acc", ADDR_ACC_VALUE, r);
    end
    acc_value_i <= 32'h0;
    wr(ADDR_PRI_THR, 32'h10);
    wr(ADDR_CNT_TARGET, 32'h3);
    wr(ADDR_CONFIG, 32'h18);
    for (int i = 1; i <= 3; i++) begin
      res(1'b0, 24'h000100, 1'b0, 1'b0);
      rchk("status", ADDR_STATUS, {27'h0, i == 3, 4'h1});
      rchk("count", ADDR_CNT_VALUE, (i == 3) ? 32'h0 : i);
      rd(ADDR_PRI_RESULT, rb);
    end
    // Gross overrange: disabled, then sticky, cleared by gain and by disable.
    wr(ADDR_CONFIG, 32'h0);
    gross_ovr_i <= 1'b1;
    repeat (OVR + 8) @(posedge ref_clk_i);
    rchk("status", ADDR_STATUS, 32'h0);
    wr(ADDR_CONFIG, 32'h4);
    repeat (OVR + 8) @(posedge ref_clk_i);
    rchk("status", ADDR_STATUS, 32'h8);
    gross_ovr_i <= 1'b0;
    repeat (2 * OVR + 8) @(posedge ref_clk_i);
    rchk("status", ADDR_STATUS, 32'h8);
    wr(ADDR_PRI_CTRL, 32'h5);
    rchk("status", ADDR_STATUS, 32'h0);
    gross_ovr_i <= 1'b1;
    repeat (OVR + 8) @(posedge ref_clk_i);
    rchk("status", ADDR_STATUS, 32'h8);
    wr(ADDR_CONFIG, 32'h0);
    rchk("status", ADDR_STATUS, 32'h0);
    gross_ovr_i <= 1'b0;
    // Interrupt only through the mask.
    res(1'b0, 24'h000007, 1'b0, 1'b0);
    #1 chk("irq", 32'h0, {31'h0, irq_o});
    wr(ADDR_IRQ_MASK, 32'h1);
    repeat (3) @(posedge ref_clk_i);
    #1 chk("irq", 32'h1, {31'h0, irq_o});
    rd(ADDR_PRI_RESULT, rb);
    repeat (3) @(posedge ref_clk_i);
    #1 chk("irq", 32'h0, {31'h0, irq_o});
    // Mid-run reset with flags and the mask set.
    cal_end_i <= 1'b1;
    @(posedge ref_clk_i);
    cal_end_i <= 1'b0;
    rd(ADDR_STATUS, rb);
    chk("status_used", 32'h8003, rb & {16'h0, ~STATUS_RSVD});
    #1 chk("irq", 32'h1, {31'h0, irq_o});
    nrst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    #1 chk("irq", 32'h0, {31'h0, irq_o});
    rchk("status", ADDR_STATUS, 32'h0);
    rchk("mask", ADDR_IRQ_MASK, {24'h0, MASK_RST});
    complete_run();
  end
endmodule : adcsf_top_tb
`default_nettype wire
